/* File: common/asmr_pkg.sv */
/*
 * Shared constants for the converter conversion-control and serial readout block.
 * Assumes a 125 MHz ref_clk and a host-driven serial clock.
 */
package asmr_pkg;
    localparam int          RES_W        = 16;   // result width
    localparam int          CNT_W        = 8;    // serial edge counter width
    localparam int          CLK_MHZ      = 125;  // ref_clk rate
    localparam int          CONV_TIME_NS = 2000; // internal conversion time, plain default
    // longest time: rounded down to whole cycles
    localparam int          CONV_CYCLES  = (CONV_TIME_NS * CLK_MHZ) / 1000;
    localparam logic [15:0] CODE_POS_FS  = 16'h7FFF;  // saturated positive code
    localparam logic [15:0] CODE_NEG_FS  = 16'h8000;  // saturated negative code
    localparam logic [7:0]  BITS_PLAIN   = 8'h10;     // edges in a plain readout
    localparam logic [7:0]  BITS_BUSY    = 8'h11;     // edges with busy flush
    localparam logic [3:0]  MSB_IDX      = 4'hF;

    typedef enum logic [1:0] {
        ST_ACQ,
        ST_CONV,
        ST_READ
    } asmr_state_t;
endpackage : asmr_pkg

/* File: rtl/asmr_readout.sv */
/*
 * Conversion control and serial readout of a 16-bit SAR converter.
 * Assumes the SAR core presents its code and range flags on ref_clk,
 * and that serialClk is the host's serial clock, possibly stopped.
 */
// Function
// - six serial modes chosen only by pin levels, no configuration word.
// - data-in high at convert-start rise selects chip-select mode, else chain.
// - in chain mode, serial clock high at that rise enables busy indicator.
// - chip-select mode arms busy when selected in the cycle that conversion completes.
// - chain with busy presents a low-to-high start bit when all are ready.
// - in 3-wire mode, convert-start rise starts conversion, data-out floats.
// - a started conversion runs to completion regardless of convert-start.
// - after conversion the device returns to acquisition and powers down.
// - 3-wire without busy drives the MSB when convert-start falls.
// - remaining bits shift out on successive serial clock falling edges.
// - each bit stays valid across both serial clock edges.
// - in 3-wire mode without busy, data-out floats at 16th falling edge or convert-start rise.
// - result is two's complement, saturating at full-scale codes.
// - chain mode shifts data-in through on falls, own result MSB first.
`timescale 1ns/10ps

module asmr_readout (
    input  wire logic        ref_clk,         // internal conversion clock
    input  wire logic        sys_rst,         // synchronous reset, active high
    input  wire logic        serialClk,       // host serial clock
    input  wire logic        convertStart,    // convert-start pin
    input  wire logic        serialDataIn,    // serial data-in pin
    input  wire logic [15:0] sarCode,         // SAR decision code
    input  wire logic        sarOverRange,    // input above full scale
    input  wire logic        sarUnderRange,   // input below full scale
    output logic             serialDataOut,   // serial data-out value
    output logic             serialDataOutEn, // high while data-out is driven
    output logic             powerDown,       // core powered down
    output logic             convActive,      // conversion in progress
    output logic             chainMode,       // chain mode selected
    output logic             busyMode         // busy indicator enabled
);

    ////////////////////////////////////////////////////////////////////////
    // serial clock domain: falling-edge counter and data-in capture

    logic                               rstS1_reg;
    logic                               rstS2_reg;
    logic [asmr_pkg::CNT_W-1:0]         cntBin_reg;
    logic [asmr_pkg::CNT_W-1:0]         cntBin_next;
    logic [asmr_pkg::CNT_W-1:0]         cntGray_reg;
    logic [asmr_pkg::CNT_W-1:0]         cntGray_next;
    logic [asmr_pkg::RES_W-1:0]         ring_reg;
    logic [asmr_pkg::RES_W-1:0]         ring_next;

    always_comb begin
        cntBin_next  = rstS2_reg ? '0 : cntBin_reg + 8'h01;
        cntGray_next = cntBin_next ^ (cntBin_next >> 1);
        ring_next    = ring_reg;
    end

    // upstream bits land in a ring indexed by edge count
    genvar gi;
    generate
        for (gi = 0; gi < asmr_pkg::RES_W; gi++) begin : g_ring
            always_ff @(negedge serialClk) begin
                if (cntBin_reg[3:0] == 4'(gi))
                    ring_reg[gi] <= serialDataIn;
                else
                    ring_reg[gi] <= ring_next[gi];
            end
        end
    endgenerate

    always_ff @(negedge serialClk) begin
        rstS1_reg   <= sys_rst;
        rstS2_reg   <= rstS1_reg;
        cntBin_reg  <= cntBin_next;
        cntGray_reg <= cntGray_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // ref_clk domain: pin synchronisers and count crossing

    logic                               cnvS1_reg;
    logic                               cnvS2_reg;
    logic                               cnvS3_reg;
    logic                               sdiS1_reg;
    logic                               sdiS2_reg;
    logic                               sclkS1_reg;
    logic                               sclkS2_reg;
    logic [asmr_pkg::CNT_W-1:0]         cntS1_reg;
    logic [asmr_pkg::CNT_W-1:0]         cntS2_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnvS1_reg  <= 1'b0;
            cnvS2_reg  <= 1'b0;
            cnvS3_reg  <= 1'b0;
            sdiS1_reg  <= 1'b0;
            sdiS2_reg  <= 1'b0;
            sclkS1_reg <= 1'b0;
            sclkS2_reg <= 1'b0;
            cntS1_reg  <= '0;
            cntS2_reg  <= '0;
        end else begin
            cnvS1_reg  <= convertStart;
            cnvS2_reg  <= cnvS1_reg;
            cnvS3_reg  <= cnvS2_reg;
            sdiS1_reg  <= serialDataIn;
            sdiS2_reg  <= sdiS1_reg;
            sclkS1_reg <= serialClk;
            sclkS2_reg <= sclkS1_reg;
            cntS1_reg  <= cntGray_reg;
            cntS2_reg  <= cntS1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ref_clk domain: conversion control and data-out driver

    asmr_pkg::asmr_state_t              state_reg;
    asmr_pkg::asmr_state_t              state_next;
    logic [15:0]                        convCnt_reg;
    logic [15:0]                        convCnt_next;
    logic                               csMode_reg;
    logic                               csMode_next;
    logic                               busyEn_reg;
    logic                               busyEn_next;
    logic [asmr_pkg::RES_W-1:0]         result_reg;
    logic [asmr_pkg::RES_W-1:0]         result_next;
    logic [asmr_pkg::CNT_W-1:0]         base_reg;
    logic [asmr_pkg::CNT_W-1:0]         base_next;
    logic                               sdo_reg;
    logic                               sdo_next;
    logic                               sdoEn_reg;
    logic                               sdoEn_next;
    logic                               pwrDn_reg;
    logic                               pwrDn_next;
    logic                               convAct_reg;
    logic                               convAct_next;
    logic                               chain_reg;
    logic                               chain_next;

    logic [asmr_pkg::CNT_W-1:0]         cntRef;
    logic [asmr_pkg::CNT_W-1:0]         edges;
    logic [asmr_pkg::CNT_W-1:0]         dataIdx;
    logic [asmr_pkg::RES_W-1:0]         satCode;
    logic                               cnvRise;
    logic                               selected;
    logic                               busyArm;
    logic                               bitSel;

    always_comb begin
        cntRef = '0;
        cntRef[asmr_pkg::CNT_W-1] = cntS2_reg[asmr_pkg::CNT_W-1];
        for (int i = asmr_pkg::CNT_W - 2; i >= 0; i--)
            cntRef[i] = cntRef[i+1] ^ cntS2_reg[i];
    end

    assign cnvRise  = cnvS2_reg & ~cnvS3_reg;
    assign selected = ~(cnvS2_reg & sdiS2_reg);   // 3-wire on convert-start, 4-wire on data-in
    assign busyArm  = busyEn_reg | (csMode_reg & selected);
    assign edges    = cntRef - base_reg;
    assign dataIdx  = busyEn_reg ? edges - 8'h01 : edges;

    // full-scale saturation of the two's complement code
    assign satCode = sarOverRange  ? asmr_pkg::CODE_POS_FS :
                     sarUnderRange ? asmr_pkg::CODE_NEG_FS : sarCode;

    // bit on the line after a given number of falls; held between falls
    always_comb begin
        if (busyEn_reg && edges == 8'h00)
            bitSel = csMode_reg ? 1'b0 : sdiS2_reg;
        else if (dataIdx[7:4] == 4'h0)
            bitSel = result_reg[asmr_pkg::MSB_IDX - dataIdx[3:0]];
        else
            bitSel = csMode_reg ? 1'b0 : ring_reg[cntRef[3:0]];
    end

    always_comb begin
        state_next   = state_reg;
        convCnt_next = convCnt_reg;
        csMode_next  = csMode_reg;
        busyEn_next  = busyEn_reg;
        result_next  = result_reg;
        base_next    = base_reg;
        sdo_next     = sdo_reg;
        sdoEn_next   = sdoEn_reg;
        pwrDn_next   = pwrDn_reg;
        case (state_reg)
            asmr_pkg::ST_ACQ, asmr_pkg::ST_READ: begin
                if (cnvRise) begin
                    state_next   = asmr_pkg::ST_CONV;
                    convCnt_next = 16'(asmr_pkg::CONV_CYCLES - 1);
                    csMode_next  = sdiS2_reg;
                    busyEn_next  = ~sdiS2_reg & sclkS2_reg;
                    sdoEn_next   = ~sdiS2_reg;
                    sdo_next     = 1'b0;
                    pwrDn_next   = 1'b0;
                end else if (state_reg == asmr_pkg::ST_READ) begin
                    sdo_next = bitSel;
                    if (csMode_reg) begin
                        if (!busyEn_reg && !selected) begin
                            // count restarts at the select edge
                            base_next  = cntRef;
                            sdoEn_next = 1'b0;
                        end else if (!selected || edges >= (busyEn_reg ?
                                     asmr_pkg::BITS_BUSY : asmr_pkg::BITS_PLAIN)) begin
                            sdoEn_next = 1'b0;
                            state_next = asmr_pkg::ST_ACQ;
                        end else begin
                            sdoEn_next = 1'b1;
                        end
                    end
                end
            end
            asmr_pkg::ST_CONV: begin
                // convert-start is ignored until the count expires
                convCnt_next = convCnt_reg - 16'h0001;
                // only the select level at the end arms busy, so a short early
                // drop to address another part is forgiven
                if (convCnt_reg == 16'h0000)
                    busyEn_next = busyArm;
                if (convCnt_reg == 16'h0000) begin
                    state_next  = asmr_pkg::ST_READ;
                    result_next = satCode;
                    base_next   = cntRef;
                    pwrDn_next  = 1'b1;
                    if (!csMode_reg) begin
                        sdoEn_next = 1'b1;
                        sdo_next   = busyArm ? sdiS2_reg : satCode[15];
                    end else if (busyArm) begin
                        sdoEn_next = 1'b1;
                        sdo_next   = 1'b0;
                    end else begin
                        sdoEn_next = 1'b0;
                        sdo_next   = satCode[15];
                    end
                end
            end
            default: begin
                state_next = asmr_pkg::ST_ACQ;
            end
        endcase
        convAct_next = (state_next == asmr_pkg::ST_CONV);
        chain_next   = ~csMode_next;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg   <= asmr_pkg::ST_ACQ;
            convCnt_reg <= 16'h0000;
            csMode_reg  <= 1'b1;
            busyEn_reg  <= 1'b0;
            result_reg  <= 16'h0000;
            base_reg    <= 8'h00;
            sdo_reg     <= 1'b0;
            sdoEn_reg   <= 1'b0;
            pwrDn_reg   <= 1'b1;
            convAct_reg <= 1'b0;
            chain_reg   <= 1'b0;
        end else begin
            state_reg   <= state_next;
            convCnt_reg <= convCnt_next;
            csMode_reg  <= csMode_next;
            busyEn_reg  <= busyEn_next;
            result_reg  <= result_next;
            base_reg    <= base_next;
            sdo_reg     <= sdo_next;
            sdoEn_reg   <= sdoEn_next;
            pwrDn_reg   <= pwrDn_next;
            convAct_reg <= convAct_next;
            chain_reg   <= chain_next;
        end
    end

    assign serialDataOut   = sdo_reg;
    assign serialDataOutEn = sdoEn_reg;
    assign powerDown       = pwrDn_reg;
    assign convActive      = convAct_reg;
    assign chainMode       = chain_reg;
    assign busyMode        = busyEn_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_mode_pick;
        @(posedge ref_clk) disable iff (sys_rst)
        (cnvRise && state_reg != asmr_pkg::ST_CONV) |=> (csMode_reg == $past(sdiS2_reg));
    endproperty
    a_mode_pick: assert property (p_mode_pick) else $error("mode not taken from data-in");

    property p_chain_busy;
        @(posedge ref_clk) disable iff (sys_rst)
        (cnvRise && state_reg != asmr_pkg::ST_CONV && !sdiS2_reg)
            |=> (busyEn_reg == $past(sclkS2_reg));
    endproperty
    a_chain_busy: assert property (p_chain_busy) else $error("chain busy option wrong");

    property p_float_start;
        @(posedge ref_clk) disable iff (sys_rst)
        (cnvRise && state_reg != asmr_pkg::ST_CONV && sdiS2_reg)
            |=> !serialDataOutEn && convActive;
    endproperty
    a_float_start: assert property (p_float_start) else $error("start did not float output");

    property p_conv_holds;
        @(posedge ref_clk) disable iff (sys_rst)
        (convActive && convCnt_reg != 16'h0000) |=> convActive;
    endproperty
    a_conv_holds: assert property (p_conv_holds) else $error("conversion cut short");

    property p_conv_len;
        @(posedge ref_clk) disable iff (sys_rst)
        (cnvRise && !convActive) |=> convActive [*8] ##[1:300] (!convActive && powerDown);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("no power down after conversion");

    property p_load;
        @(posedge ref_clk) disable iff (sys_rst)
        (convActive && convCnt_reg == 16'h0000) |=> (result_reg == $past(satCode))
            && !$past(sarOverRange) || result_reg == asmr_pkg::CODE_POS_FS;
    endproperty
    a_load: assert property (p_load) else $error("result not loaded at end");

    property p_busy_arm;
        @(posedge ref_clk) disable iff (sys_rst)
        (convActive && convCnt_reg == 16'h0000 && csMode_reg && selected) |=> busyEn_reg;
    endproperty
    a_busy_arm: assert property (p_busy_arm) else $error("busy not armed on early select");

    property p_busy_idle;
        @(posedge ref_clk) disable iff (sys_rst)
        (convActive && convCnt_reg == 16'h0000 && csMode_reg && !selected && !busyEn_reg)
            |=> !busyEn_reg;
    endproperty
    a_busy_idle: assert property (p_busy_idle) else $error("busy armed without select");

    property p_msb_select;
        @(posedge ref_clk) disable iff (sys_rst)
        (state_reg == asmr_pkg::ST_READ && csMode_reg && !busyEn_reg && !cnvRise
            && selected && edges == 8'h00)
            |=> serialDataOutEn && (serialDataOut == result_reg[15]);
    endproperty
    a_msb_select: assert property (p_msb_select) else $error("msb not driven on select");

    property p_float_end;
        @(posedge ref_clk) disable iff (sys_rst)
        (state_reg == asmr_pkg::ST_READ && csMode_reg && !busyEn_reg && !cnvRise
            && edges >= asmr_pkg::BITS_PLAIN) |=> !serialDataOutEn;
    endproperty
    a_float_end: assert property (p_float_end) else $error("output not floated after 16 bits");

endmodule : asmr_readout

/* File: dv/asmr_host.sv */
/*
 * Host model for the converter readout: drives convert-start, serial clock
 * and data-in, and reads data-out. Assumes a 48 ns serial clock that runs
 * only inside frames; a chain's upstream converter is modelled by upWord.
 */
`timescale 1ns/10ps

module asmr_host (
    input  wire logic ref_clk,         // device clock, paces pin changes
    input  wire logic serialDataOut,   // data-out value
    input  wire logic serialDataOutEn, // data-out driven
    output logic      convertStart,    // convert-start pin
    output logic      serialClk,       // serial clock, still outside frames
    output logic      serialDataIn     // data-in pin
);
    logic        lastDrv; // last bit really driven
    logic        sdoLine; // level seen on the wire
    logic [15:0] upWord;  // upstream result in a two-part chain
    logic        feedUp;  // data-in fed by the upstream part

    // floating line reads as the inverse, so a stale bit never matches
    assign sdoLine = serialDataOutEn ? serialDataOut : ~lastDrv;

    always @(posedge ref_clk) begin
        if (serialDataOutEn) lastDrv <= serialDataOut;
    end

    initial begin
        convertStart = 1'b0;
        serialClk    = 1'b0;
        serialDataIn = 1'b1;
        lastDrv      = 1'b0;
        upWord       = 16'h0000;
        feedUp       = 1'b0;
    end

    task automatic pins(input logic convert_start, input logic serial_data_in, input logic sck);
        @(negedge ref_clk);
        convertStart = convert_start;
        serialDataIn = serial_data_in;
        serialClk    = sck;
    endtask : pins

    task automatic start(input logic serial_data_in, input logic sck);
        pins(1'b0, serial_data_in, sck);
        repeat (5) @(negedge ref_clk); // quiet before the rise
        convertStart = 1'b1;           // mode set by levels
        repeat (2) @(negedge ref_clk); // quiet after the rise
    endtask : start

    // sampled just before each fall: the bit stands across both edges
    task automatic shift(input int n, output logic [31:0] word);
        word = 32'h0000_0000;
        #3.1;
        if (feedUp) serialDataIn = upWord[15];
        for (int i = 0; i < n; i++) begin
            serialClk = 1'b1;
            #24;
            word = {word[30:0], sdoLine};
            serialClk = 1'b0;
            #10;
            upWord = {upWord[14:0], 1'b0};
            if (feedUp) serialDataIn = upWord[15]; // upstream output delay
            #14;
        end
    endtask : shift
endmodule : asmr_host

/* File: dv/tb.sv */
/*
 * Self-checking bench for asmr_readout with the host model on its pins.
 * Assumes the package conversion length and a plain SAR code source.
 */
`timescale 1ns/10ps

module tb;
    logic        ref_clk;
    logic        sys_rst;
    logic        serialClk;
    logic        convertStart;
    logic        serialDataIn;
    logic [15:0] sarCode;
    logic        sarOverRange;
    logic        sarUnderRange;
    logic        serialDataOut;
    logic        serialDataOutEn;
    logic        powerDown;
    logic        convActive;
    logic        chainMode;
    logic        busyMode;
    int          errors;
    int          cmp_count;
    logic [31:0] word;

    asmr_readout asmr_readout_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .serialClk(serialClk),
        .convertStart(convertStart), .serialDataIn(serialDataIn),
        .sarCode(sarCode), .sarOverRange(sarOverRange),
        .sarUnderRange(sarUnderRange), .serialDataOut(serialDataOut),
        .serialDataOutEn(serialDataOutEn), .powerDown(powerDown),
        .convActive(convActive), .chainMode(chainMode), .busyMode(busyMode)
    );

    asmr_host asmr_host_i (
        .ref_clk(ref_clk), .serialDataOut(serialDataOut),
        .serialDataOutEn(serialDataOutEn), .convertStart(convertStart),
        .serialClk(serialClk), .serialDataIn(serialDataIn)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // bounded wait; the figure is the conversion length left after the call
    task automatic wait_conv;
        int n;
        n = 0;
        while (convActive !== 1'b0 && n < 400) begin
            cyc(1);
            n++;
        end
        chk("convLength", 1, (n >= 240 && n <= 256));
        chk("powerDown", 1, powerDown);
    endtask : wait_conv

    ////////////////////////////////////////////////////////////////////////
    task automatic t_cs_plain(input logic [15:0] code, input logic ovr, input logic unr,
                              input logic [15:0] exp, input int nBits);
        sarCode = code;
        sarOverRange = ovr;
        sarUnderRange = unr;
        asmr_host_i.start(1'b1, 1'b0);
        cyc(3);
        chk("convActive", 1, convActive);
        chk("outEnConv", 0, serialDataOutEn);
        chk("chainMode", 0, chainMode);
        asmr_host_i.pins(1'b0, 1'b1, 1'b0);            // short select of another part
        cyc(2);
        asmr_host_i.pins(1'b1, 1'b1, 1'b0);            // rise ignored mid-conversion
        wait_conv;
        chk("busyMode", 0, busyMode);
        sarCode = ~code;
        asmr_host_i.pins(1'b0, 1'b1, 1'b0);
        cyc(6);
        chk("outEnSel", 1, serialDataOutEn);
        asmr_host_i.shift(nBits, word);
        if (nBits == 16) begin
            chk("csWord", {16'h0000, exp}, word);
        end else begin
            chk("csHead", {28'h000_0000, exp[15:12]}, word);
            asmr_host_i.pins(1'b1, 1'b1, 1'b0);
        end
        cyc(6);
        chk("outEnEnd", 0, serialDataOutEn);
        // the rise that cut the frame also started a conversion
        if (nBits != 16) wait_conv;
        $display("test cs plain %h done", code);
    endtask : t_cs_plain

    task automatic t_cs_busy(input logic [15:0] code);
        sarCode = code;
        sarOverRange = 1'b0;
        sarUnderRange = 1'b0;
        asmr_host_i.start(1'b1, 1'b0);
        asmr_host_i.pins(1'b1, 1'b0, 1'b0); // select on data-in before the end
        wait_conv;
        chk("busyMode", 1, busyMode);
        chk("busyFlag", 32'h2, {serialDataOutEn, serialDataOut});
        asmr_host_i.shift(17, word);
        chk("busyWord", {15'h0000, 1'b0, code}, word);
        cyc(6);
        chk("outEnEnd", 0, serialDataOutEn);
        asmr_host_i.pins(1'b1, 1'b1, 1'b0);
        $display("test cs busy done");
    endtask : t_cs_busy

    task automatic t_chain(input logic [15:0] code, input logic busy);
        sarCode = code;
        asmr_host_i.start(1'b0, busy);
        asmr_host_i.pins(1'b1, 1'b0, 1'b0);
        chk("chainMode", 1, chainMode);
        chk("chainBusy", busy, busyMode);
        asmr_host_i.upWord = 16'h3C5A;
        asmr_host_i.feedUp = !busy;
        wait_conv;
        if (!busy) begin
            chk("chainMsb", {1'b1, code[15]}, {serialDataOutEn, serialDataOut});
            asmr_host_i.shift(32, word);
            chk("chainWord", {code, 16'h3C5A}, word);
        end else begin
            chk("chainWait", 32'h2, {serialDataOutEn, serialDataOut});
            asmr_host_i.pins(1'b1, 1'b1, 1'b0);
            cyc(6);
            chk("startBit", 32'h3, {serialDataOutEn, serialDataOut});
            asmr_host_i.shift(17, word);
            chk("chainBusyWord", {15'h0000, 1'b1, code}, word);
        end
        asmr_host_i.feedUp = 1'b0;
        $display("test chain busy=%0d done", busy);
    endtask : t_chain

    // link-side count clears only on serial clock falls, two falls behind the reset
    task automatic t_link_reset;
        sys_rst = 1'b1;
        asmr_host_i.shift(3, word);
        cyc(1);
        sys_rst = 1'b0;
        cyc(1);
        chk("resetOuts2", 32'h8,
            {serialDataOutEn, powerDown, convActive, chainMode, busyMode});
        asmr_host_i.shift(2, word);                // lets the link-side reset go
        cyc(2);
        $display("test link reset done");
    endtask : t_link_reset

    ////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        sarCode = 16'h0000;
        sarOverRange = 1'b0;
        sarUnderRange = 1'b0;
        cyc(3);
        sys_rst = 1'b0;
        cyc(1);
        chk("resetOuts", 32'h8, {serialDataOutEn, powerDown, convActive, chainMode, busyMode});
        t_link_reset;
        t_cs_plain(16'hA5C3, 1'b0, 1'b0, 16'hA5C3, 16);
        t_cs_plain(16'h1234, 1'b1, 1'b0, 16'h7FFF, 16);
        t_cs_plain(16'h1234, 1'b0, 1'b1, 16'h8000, 4);
        t_cs_busy(16'h9E61);
        t_chain(16'hC3A5, 1'b0);
        t_chain(16'h5A0F, 1'b1);
        stop_test;
    end

    // whole run is about 20 us; a hang ends well after that
    initial begin
        #200000;
        errors++;
        $display("unexpected watchdog expected done seen hang");
        stop_test;
    end
endmodule : tb
